// ===== shared/sre_pkg.sv
// Constants, types and helper functions for the serial RAM and EEPROM access engine.
// Assumes a 20 MHz core clock and a free-running link clock that oversamples the bus pins.
// How it works
// R1 - Send byte with command in RAM range loads the address pointer.
// R2 - Send byte with command 0xFE asks to erase the page under the pointer.
// R3 - Erase needs pointer set by previous write byte and enable bit 2 of 0x90.
// R4 - Erase starts when its command byte arrives; master may stop right away.
// R5 - Erase lasts about 20 ms and any access meanwhile is not acknowledged.
// R6 - Write byte with command 0x00 to 0xDF stores data into that RAM byte.
// R7 - Write byte with command 0xF8 to 0xFB sets the EEPROM pointer.
// R8 - Write word with command 0xF8 to 0xFB programs second byte at that address.
// R9 - Erase uses only the top three low-address bits to pick a 32-byte page; the code takes address bits 9 to 5.
// R10 - Block write is 0xFC, count, then data bytes, all acknowledged, 32 at most.
// R11 - Block write continues from a pointer set beforehand by send or write byte.
// R12 - EEPROM block writes may cross pages; master keeps below 0xFBFF.
// R13 - Each EEPROM byte takes about 250 us while SCL is held low.
// R14 - Receive byte returns the byte at the current pointer.
// R15 - Master ends a receive byte with no-acknowledge and stop.
// R16 - Block read is command 0xFD, repeated start, read address acknowledged.
// R17 - Block read sends count 0x20 then exactly 32 bytes from consecutive addresses.
// R18 - Address and command of a send byte are acknowledged before the stop.
// R19 - Master may stop a write after its first data byte.
// R20 - Optional error byte follows RAM, EEPROM and block writes and block reads.
// R21 - Block read sends the check byte after data; master then NACKs and stops.
// R22 - Error byte is a CRC-8 check sequence over the transaction.
// R23 - Slave address is 10011 followed by the two address-select pins.
// R24 - Bus access is refused for about 1 ms after reset while RAM loads.
// R25 - With the erase-enable bit clear the erase command erases nothing.
// R26 - CRC-8 uses x^8+x^2+x+1, zero start, all bytes including addresses.
// R27 - Pointer advances by one after each block read or block write byte.
package sre_pkg;

  localparam int          CLK_PERIOD_NS = 50;
  localparam int          BOOT_TIME_US  = 1000;
  localparam int          ERASE_TIME_US = 20000;
  localparam int          PROG_TIME_US  = 250;
  localparam int          BOOT_CYC      = (BOOT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ERASE_CYC     = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          PROG_CYC      = (PROG_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 19;

  localparam logic [4:0]  ADDR_FIXED    = 5'h13;
  localparam logic [7:0]  RAM_TOP       = 8'hDF;
  localparam logic [7:0]  EE_HI_FIRST   = 8'hF8;
  localparam logic [7:0]  EE_HI_LAST    = 8'hFB;
  localparam logic [5:0]  EE_BASE_HI6   = 6'h3E;
  localparam logic [7:0]  CMD_BLK_WR    = 8'hFC;
  localparam logic [7:0]  CMD_BLK_RD    = 8'hFD;
  localparam logic [7:0]  CMD_ERASE     = 8'hFE;
  localparam logic [7:0]  BLK_RD_COUNT  = 8'h20;
  localparam logic [5:0]  BLK_MAX       = 6'h20;
  localparam logic [5:0]  BLK_PEC_IDX   = 6'h21;
  localparam logic [7:0]  UPD_CFG_ADDR  = 8'h90;
  localparam int          ERASE_EN_BIT  = 2;
  localparam logic [7:0]  ERASED        = 8'hFF;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam int          RAM_WORDS     = 224;
  localparam int          EE_WORDS      = 1024;
  localparam logic [5:0]  PAGE_BYTES    = 6'h20;
  localparam logic [5:0]  LN_RST        = 6'h13;

  typedef enum logic [1:0] {OP_RD, OP_WR_RAM, OP_WR_EE, OP_ERASE} sre_op_e;

  typedef struct packed {
    sre_op_e     op;
    logic [15:0] addr;
    logic [7:0]  data;
  } sre_req_s;

  typedef enum logic [7:0] {
    LK_IDLE = 8'h01, LK_RX = 8'h02, LK_DEC = 8'h04, LK_ACK = 8'h08,
    LK_WAIT = 8'h10, LK_LOAD = 8'h20, LK_TX = 8'h40, LK_MACK = 8'h80
  } sre_link_e;

  typedef enum logic [3:0] {
    CR_BOOT = 4'h1, CR_IDLE = 4'h2, CR_PROG = 4'h4, CR_ERASE = 4'h8
  } sre_core_e;

  function automatic logic sre_is_ram_cmd(input logic [7:0] b);
    return b <= RAM_TOP;
  endfunction

  function automatic logic sre_is_ee_hi(input logic [7:0] b);
    return (b >= EE_HI_FIRST) && (b <= EE_HI_LAST);
  endfunction

  function automatic logic sre_is_ee(input logic [15:0] a);
    return a[15:10] == EE_BASE_HI6;
  endfunction

  function automatic logic [7:0] sre_crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) begin
      x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

endpackage

// ===== src/sre_top.sv
// Serial bus slave engine giving a bus master access to RAM and EEPROM storage.
// Assumes open-drain SCL and SDA resolved outside, and a link clock well above the bus rate.
`timescale 1ns/1ns
module sre_top
  import sre_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES  = BOOT_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC,
  parameter int unsigned PROG_CYCLES  = PROG_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic linkClk,
  input  wire logic sclIn,
  input  wire logic sdaIn,
  input  wire logic addrSelectHiPin,
  input  wire logic addrSelectLoPin,
  output logic      sclOut,
  output logic      sclOe,
  output logic      sdaOut,
  output logic      sdaOe
);

  // Link domain state.
  sre_link_e   state;
  logic [5:0]  lnS1;
  logic [5:0]  lnS2;
  logic [5:0]  lnS3;
  logic [5:0]  lnLvl;
  logic [5:0]  lnPrev;
  logic [3:0]  bitCnt;
  logic [7:0]  shift;
  logic [7:0]  txSh;
  logic [5:0]  idx;
  logic [5:0]  rIdx;
  logic [5:0]  blkLeft;
  logic [7:0]  cmd;
  logic [15:0] ptr;
  logic [7:0]  crc;
  logic        isRead;
  logic        blkRd;
  logic        armed;
  logic        pend;
  logic        waitRd;
  logic        mAck;
  logic        reqTgl;
  sre_req_s    reqPay;

  // Core domain state.
  sre_core_e        cState;
  logic [CNT_W-1:0] cnt;
  logic [2:0]       crSync;
  logic             crLvl;
  logic             crPrev;
  logic             ackTgl;
  logic             coreBusy;
  logic [7:0]       rdData;
  logic [4:0]       page;
  logic [7:0]       ram [0:RAM_WORDS-1];
  logic [7:0]       ee  [0:EE_WORDS-1];

  // Pin and cross-domain inputs of the link side, filtered by the 2nd/3rd stage agreement.
  wire [5:0] lnRaw   = {ackTgl, coreBusy, addrSelectHiPin, addrSelectLoPin, sdaIn, sclIn};
  wire [5:0] lnAgree = ~(lnS2 ^ lnS3);
  wire       sclLvl  = lnLvl[0];
  wire       sdaLvl  = lnLvl[1];
  wire       busyLvl = lnLvl[4];
  wire       ackEvt  = lnLvl[5] ^ lnPrev[5];
  wire       sclRise = sclLvl & ~lnPrev[0];
  wire       sclFall = ~sclLvl & lnPrev[0];
  wire       startC  = sclLvl & lnPrev[0] & lnPrev[1] & ~sdaLvl;
  wire       stopC   = sclLvl & lnPrev[0] & ~lnPrev[1] & sdaLvl;

  // Byte decode after the eighth bit of a received byte.
  wire       addrHit = shift[7:1] == {ADDR_FIXED, lnLvl[3], lnLvl[2]}; // R23
  wire       decEra  = (idx == 6'h01) && (shift == CMD_ERASE) && armed;       // R2 R3
  wire       decRamW = (idx == 6'h02) && sre_is_ram_cmd(cmd);                  // R6
  wire       decEeW  = (idx == 6'h03) && sre_is_ee_hi(cmd);                    // R8
  wire       decBlkW = (idx >= 6'h03) && (cmd == CMD_BLK_WR) && (blkLeft != 6'h00); // R10
  wire       decIss  = (state == LK_DEC) && (decEra | decRamW | decEeW | decBlkW);
  wire       rdData1 = blkRd && (rIdx >= 6'h01) && (rIdx <= BLK_MAX);
  wire       needFet = blkRd ? rdData1 : (rIdx == 6'h00);                        // R14 R17
  wire       loadIss = (state == LK_LOAD) && needFet;
  wire [7:0] loadVal = (blkRd && rIdx == 6'h00) ? BLK_RD_COUNT :
                       (blkRd && rIdx == BLK_PEC_IDX) ? crc : ERASED;            // R17 R21
  wire sre_op_e decOp = decEra ? OP_ERASE : decRamW ? OP_WR_RAM :
                        (decEeW | sre_is_ee(ptr)) ? OP_WR_EE : OP_WR_RAM;
  wire [15:0] decAdr  = decRamW ? {8'h00, cmd} : ptr;
  wire sre_req_s issReq = loadIss ? sre_req_s'{op: OP_RD, addr: ptr, data: 8'h00}
                                  : sre_req_s'{op: decOp, addr: decAdr, data: shift};
  wire       next_sdaOe = (state == LK_ACK) | ((state == LK_TX) & ~txSh[7]);
  // SDA settles one link cycle before a stretch ends, so it never moves as SCL rises.
  wire       next_sclOe = (state == LK_WAIT) | (sclOe & (sdaOe != next_sdaOe)); // R13

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      lnS1   <= LN_RST;
      lnS2   <= LN_RST;
      lnS3   <= LN_RST;
      lnLvl  <= LN_RST;
      lnPrev <= LN_RST;
    end else begin
      lnS1   <= lnRaw;
      lnS2   <= lnS1;
      lnS3   <= lnS2;
      lnLvl  <= (lnAgree & lnS3) | (~lnAgree & lnLvl);
      lnPrev <= lnLvl;
    end
  end

  // The request payload only changes while no request is pending, so the core reads it safely.
  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      reqTgl <= 1'b0;
      reqPay <= '0;
      pend   <= 1'b0;
      waitRd <= 1'b0;
    end else if (decIss | loadIss) begin
      reqTgl <= ~reqTgl;
      reqPay <= issReq;
      pend   <= 1'b1;
      waitRd <= loadIss;
    end else if (ackEvt) begin
      pend   <= 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      sclOe  <= 1'b0;
      sdaOe  <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      sclOe  <= next_sclOe;
      sdaOe  <= next_sdaOe;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  always_ff @(posedge linkClk or negedge rstn) begin
    if (!rstn) begin
      state   <= LK_IDLE;
      bitCnt  <= 4'h0;
      shift   <= 8'h00;
      txSh    <= 8'h00;
      idx     <= 6'h00;
      rIdx    <= 6'h00;
      blkLeft <= 6'h00;
      cmd     <= 8'h00;
      ptr     <= 16'h0000;
      crc     <= 8'h00;
      isRead  <= 1'b0;
      blkRd   <= 1'b0;
      armed   <= 1'b0;
      mAck    <= 1'b0;
    end else if (stopC) begin
      state <= LK_IDLE;
      blkRd <= 1'b0;
    end else if (startC) begin
      // A repeated start keeps the check sum running across both halves of a block read.
      state  <= LK_RX;
      bitCnt <= 4'h0;
      idx    <= 6'h00;
      isRead <= 1'b0;
      if (state == LK_IDLE) begin
        crc <= 8'h00; // R26
      end
    end else begin
      unique case (state)
        LK_IDLE: begin
        end
        LK_RX: begin
          if (sclRise) begin
            shift  <= {shift[6:0], sdaLvl};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == 4'h8) begin
            state <= LK_DEC;
          end
        end
        LK_DEC: begin
          crc   <= sre_crc8(crc, shift); // R22 R26
          idx   <= (idx == 6'h3F) ? idx : idx + 6'h01;
          state <= decIss ? LK_WAIT : LK_ACK; // R18
          if (idx == 6'h00) begin
            if (!addrHit || busyLvl) begin
              state <= LK_IDLE; // R5 R24
            end
            isRead <= shift[0];
            rIdx   <= 6'h00;
          end else if (idx == 6'h01) begin
            cmd   <= shift;
            armed <= 1'b0;
            blkRd <= shift == CMD_BLK_RD; // R16
            if (sre_is_ram_cmd(shift)) begin
              ptr <= {8'h00, shift}; // R1 R11
            end
          end else if (idx == 6'h02 && sre_is_ee_hi(cmd)) begin
            ptr   <= {cmd, shift}; // R7 R11
            armed <= 1'b1; // R3
          end else if (idx == 6'h02 && cmd == CMD_BLK_WR) begin
            blkLeft <= (shift > BLK_RD_COUNT) ? BLK_MAX : shift[5:0]; // R10
          end else if (decBlkW) begin
            ptr     <= ptr + 16'h0001; // R12 R27
            blkLeft <= blkLeft - 6'h01;
          end
          // Surplus bytes, such as the trailing error byte, are acknowledged and dropped.
        end
        LK_ACK: begin
          if (sclFall) begin
            state  <= isRead ? LK_LOAD : LK_RX;
            bitCnt <= 4'h0;
          end
        end
        LK_WAIT: begin
          if (!pend) begin
            if (waitRd) begin
              txSh   <= rdData;
              crc    <= sre_crc8(crc, rdData);
              bitCnt <= 4'h0;
              state  <= LK_TX;
            end else begin
              state <= LK_ACK; // R4
            end
          end
        end
        LK_LOAD: begin
          if (needFet) begin
            state <= LK_WAIT;
            if (blkRd) begin
              ptr <= ptr + 16'h0001; // R27
            end
          end else begin
            txSh   <= loadVal;
            crc    <= sre_crc8(crc, loadVal); // R20
            bitCnt <= 4'h0;
            state  <= LK_TX;
          end
        end
        LK_TX: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == 4'h8) begin
              state <= LK_MACK;
            end else begin
              txSh <= {txSh[6:0], 1'b0};
            end
          end
        end
        LK_MACK: begin
          if (sclRise) begin
            mAck <= ~sdaLvl;
          end else if (sclFall) begin
            rIdx  <= (rIdx == 6'h3F) ? rIdx : rIdx + 6'h01;
            state <= mAck ? LK_LOAD : LK_IDLE; // R15 R21
          end
        end
      endcase
    end
  end

  // Core side: request toggle crosses with the same three-stage agreement filter.
  wire       reqEvt  = crLvl ^ crPrev;
  wire       crAgree = crSync[1] == crSync[2];
  wire [15:0] rqA    = reqPay.addr;
  wire       ramOk   = (rqA[15:8] == 8'h00) && sre_is_ram_cmd(rqA[7:0]);
  wire       eeOk    = sre_is_ee(rqA);
  wire       eraseEn = ram[UPD_CFG_ADDR][ERASE_EN_BIT]; // R3 R25
  wire       idleReq = (cState == CR_IDLE) && reqEvt;
  wire [7:0] rdVal   = eeOk ? ee[rqA[9:0]] : ramOk ? ram[rqA[7:0]] : 8'h00;
  wire       bootCp  = (cState == CR_BOOT) && (cnt < CNT_W'(RAM_WORDS));
  wire       ramWe   = bootCp | (idleReq && reqPay.op == OP_WR_RAM && ramOk);
  wire [7:0] ramWa   = bootCp ? cnt[7:0] : rqA[7:0];
  wire [7:0] ramWd   = bootCp ? ee[cnt[9:0]] : reqPay.data;
  wire       eraseWr = (cState == CR_ERASE) && (cnt < CNT_W'(PAGE_BYTES));
  wire       eeWe    = eraseWr | (idleReq && reqPay.op == OP_WR_EE && eeOk);
  wire [9:0] eeWa    = eraseWr ? {page, cnt[4:0]} : rqA[9:0]; // R9
  wire [7:0] eeWd    = eraseWr ? ERASED : reqPay.data;
  wire       bootEnd = cnt == CNT_W'(BOOT_CYCLES - 1);
  wire       progEnd = cnt == CNT_W'(PROG_CYCLES - 1);
  wire       eraEnd  = cnt == CNT_W'(ERASE_CYCLES - 1);

  // Storage has no reset; EEPROM contents survive a reset just as nonvolatile cells would, and boot reloads RAM from them.
  always_ff @(posedge ref_clk) begin
    if (ramWe) begin
      ram[ramWa] <= ramWd; // R6
    end
    if (eeWe) begin
      ee[eeWa] <= eeWd; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      crSync <= 3'h0;
      crLvl  <= 1'b0;
      crPrev <= 1'b0;
    end else begin
      crSync <= {crSync[1:0], reqTgl};
      crLvl  <= crAgree ? crSync[2] : crLvl;
      crPrev <= crLvl;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cState   <= CR_BOOT;
      cnt      <= '0;
      ackTgl   <= 1'b0;
      rdData   <= 8'h00;
      page     <= 5'h00;
      coreBusy <= 1'b1;
    end else begin
      coreBusy <= (cState == CR_BOOT) | (cState == CR_ERASE); // R5 R24
      unique case (cState)
        CR_BOOT: begin
          cnt <= cnt + 1'b1;
          if (bootEnd) begin
            cnt    <= '0;
            cState <= CR_IDLE; // R24
          end
        end
        CR_IDLE: begin
          if (reqEvt) begin
            unique case (reqPay.op)
              OP_RD: begin
                rdData <= rdVal; // R14
                ackTgl <= ~ackTgl;
              end
              OP_WR_RAM: begin
                ackTgl <= ~ackTgl;
              end
              OP_WR_EE: begin
                if (eeOk) begin
                  cState <= CR_PROG; // R13
                end else begin
                  ackTgl <= ~ackTgl;
                end
              end
              OP_ERASE: begin
                ackTgl <= ~ackTgl; // R4
                page   <= rqA[9:5];
                if (eraseEn) begin
                  cState <= CR_ERASE; // R2
                end
              end
            endcase
          end
        end
        CR_PROG: begin
          cnt <= cnt + 1'b1;
          if (progEnd) begin
            cnt    <= '0;
            ackTgl <= ~ackTgl; // R13
            cState <= CR_IDLE;
          end
        end
        CR_ERASE: begin
          cnt <= cnt + 1'b1;
          if (eraEnd) begin
            cnt    <= '0;
            cState <= CR_IDLE; // R5
          end
        end
      endcase
    end
  end

endmodule

// ===== verification/sre_top_monitor.sv
// Pin-level checks for the serial RAM and EEPROM engine.
// Assumes sclIn and sdaIn carry the resolved open-drain wire levels.
`timescale 1ns/1ns
module sre_top_monitor
  import sre_pkg::*;
#(
  parameter int unsigned BOOT_CYCLES = BOOT_CYC,
  parameter int unsigned PROG_CYCLES = PROG_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic linkClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  logic [15:0] bootCnt;
  logic [15:0] holdCnt;

  // The count stops at its limit so a long run never wraps back into the boot window.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      bootCnt <= 16'h0000;
    else if (bootCnt < 16'(BOOT_CYCLES))
      bootCnt <= bootCnt + 16'h0001;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      holdCnt <= 16'h0000;
    else
      holdCnt <= sclOe ? holdCnt + 16'h0001 : 16'h0000;
  end

  scl_open_drain_a: assert property (@(posedge ref_clk) disable iff (!rstn) sclOut == 1'b0)
    else $error("SCL output level not low");
  sda_open_drain_a: assert property (@(posedge ref_clk) disable iff (!rstn) sdaOut == 1'b0)
    else $error("SDA output level not low");
  boot_silent_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    bootCnt < 16'(BOOT_CYCLES) |-> !sdaOe && !sclOe)
    else $error("bus driven during boot");
  stretch_bound_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    holdCnt <= 16'(PROG_CYCLES + 64))
    else $error("clock stretch too long");
  sda_low_phase_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $changed(sdaOe) |-> !sclIn)
    else $error("SDA changed while SCL high");
  stretch_low_a: assert property (@(posedge linkClk) disable iff (!rstn)
    $rose(sclOe) |-> !sclIn)
    else $error("stretch began while SCL high");
  stop_release_a: assert property (@(posedge linkClk) disable iff (!rstn)
    sclIn && $past(sclIn) && $rose(sdaIn) |=> (!sdaOe && !sclOe) [*8])
    else $error("bus held after stop");
  ack_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(sdaOe) |-> ##[1:1000] !sdaOe)
    else $error("SDA held too long");
endmodule

bind sre_top sre_top_monitor #(.BOOT_CYCLES(BOOT_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon (
  .ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ===== verification/sre_master.sv
// Behavioural bus master that pulls SCL and SDA low through its enables.
// Assumes the bench resolves both wires with pull-ups and feeds them back.
`timescale 1ns/1ns
module sre_master
  import sre_pkg::*;
#(
  parameter int HALF = 16
) (
  input  wire logic ref_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sclLow,
  output logic      sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end

  task automatic waitHalf();
    repeat (HALF) @(posedge ref_clk);
  endtask

  task automatic lines(input logic c, input logic d);
    @(posedge ref_clk) begin
      sclLow <= c;
      sdaLow <= d;
    end
    waitHalf();
  endtask

  // The clock is let go and then sensed, so a slave that stretches it is waited out.
  task automatic pulse(output logic v);
    int n;
    n = 0;
    @(posedge ref_clk) sclLow <= 1'b0;
    while (scl !== 1'b1 && n < 20000) begin
      @(posedge ref_clk);
      n++;
    end
    waitHalf();
    v = sda;
    @(posedge ref_clk) sclLow <= 1'b1;
    waitHalf();
  endtask

  task automatic start();
    lines(1'b1, 1'b0);
    lines(1'b0, 1'b0);
    lines(1'b0, 1'b1);
    lines(1'b1, 1'b1);
  endtask

  task automatic stop();
    lines(1'b1, 1'b1);
    lines(1'b0, 1'b1);
    lines(1'b0, 1'b0);
  endtask

  task automatic bitIo(input logic d, output logic v);
    @(posedge ref_clk) sdaLow <= !d;
    repeat (HALF * 3 / 4) @(posedge ref_clk);
    pulse(v);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bitIo(b[i], v);
    bitIo(1'b1, v);
    ack = (v === 1'b0);
  endtask

  task automatic recvByte(input logic ackIt, output logic [7:0] b);
    logic v;
    for (int i = 7; i >= 0; i--) bitIo(1'b1, b[i]);
    bitIo(!ackIt, v);
  endtask
endmodule

// ===== verification/sre_top_bench.sv
// Self-checking bench for the serial RAM and EEPROM engine.
// Assumes the master model and the bound pin checker are compiled alongside.
`timescale 1ns/1ns
module sre_top_bench
  import sre_pkg::*;
();
  localparam int         BOOT  = 600;
  localparam int         ERASE = 3000;
  localparam int         PROG  = 16;
  localparam logic [7:0] AW    = {ADDR_FIXED, 2'b10, 1'b0};
  localparam logic [7:0] AR    = {ADDR_FIXED, 2'b10, 1'b1};
  logic ref_clk;
  logic linkClk;
  logic rstn;
  logic hiPin;
  logic loPin;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic mScl;
  logic mSda;
  wire  scl = !(sclOe || mScl);
  wire  sda = !(sdaOe || mSda);
  int   bad_count = 0;
  int   samples_checked = 0;
  int   cycles = 0;

  sre_top #(.BOOT_CYCLES(BOOT), .ERASE_CYCLES(ERASE), .PROG_CYCLES(PROG)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .linkClk(linkClk), .sclIn(scl), .sdaIn(sda),
    .addrSelectHiPin(hiPin), .addrSelectLoPin(loPin), .sclOut(sclOut), .sclOe(sclOe),
    .sdaOut(sdaOut), .sdaOe(sdaOe));
  sre_master #(.HALF(16)) host (
    .ref_clk(ref_clk), .scl(scl), .sda(sda), .sclLow(mScl), .sdaLow(mSda));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #32 linkClk = ~linkClk;
  end

  function automatic logic [7:0] crcStep(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    repeat (8) x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic put(input logic [7:0] b, input logic expAck);
    logic a;
    host.sendByte(b, a);
    check({7'h00, a}, {7'h00, expAck});
  endtask

  task automatic wrSeq(input logic [7:0] q[$]);
    host.start();
    foreach (q[i]) put(q[i], 1'b1);
    host.stop();
  endtask

  task automatic rdOne(input logic [7:0] exp);
    logic [7:0] d;
    host.start();
    put(AR, 1'b1);
    host.recvByte(1'b0, d);
    check(d, exp);
    host.stop();
  endtask

  task automatic testBoot();
    host.start();
    put(AW, 1'b0);
    host.stop();
    repeat (BOOT) @(posedge ref_clk);
    $display("test boot done");
  endtask

  task automatic testRam();
    wrSeq('{AW, 8'h10, 8'hA5});
    wrSeq('{AW, 8'h10});
    rdOne(8'hA5);
    host.start();
    put({ADDR_FIXED, 2'b11, 1'b0}, 1'b0);
    host.stop();
    $display("test ram done");
  endtask

  task automatic testErase();
    wrSeq('{AW, UPD_CFG_ADDR, 8'h01 << ERASE_EN_BIT});
    wrSeq('{AW, 8'hF9, 8'h5A});
    wrSeq('{AW, CMD_ERASE});
    host.start();
    put(AW, 1'b0);
    host.stop();
    repeat (ERASE) @(posedge ref_clk);
    wrSeq('{AW, 8'hF9, 8'h40});
    rdOne(ERASED);
    wrSeq('{AW, 8'hF9, 8'h41, 8'h3C});
    wrSeq('{AW, 8'hF9, 8'h41});
    rdOne(8'h3C);
    wrSeq('{AW, 8'hF9, 8'h5F});
    wrSeq('{AW, CMD_BLK_WR, 8'h02, 8'h11, 8'h22});
    wrSeq('{AW, 8'hF9, 8'h5F});
    rdOne(8'h11);
    wrSeq('{AW, 8'hF9, 8'h60});
    rdOne(8'h22);
    $display("test erase done");
  endtask

  task automatic testNoErase();
    wrSeq('{AW, UPD_CFG_ADDR, 8'h00});
    wrSeq('{AW, 8'hF9, 8'h41});
    wrSeq('{AW, CMD_ERASE});
    wrSeq('{AW, 8'hF9, 8'h41});
    rdOne(8'h3C);
    $display("test erase disabled done");
  endtask

  task automatic testBlock();
    logic [7:0] q[$];
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] crc;
    q = '{AW, CMD_BLK_WR, 8'h20};
    for (int i = 0; i < 32; i++) q.push_back(8'h40 + 8'(i));
    wrSeq('{AW, 8'h20});
    wrSeq(q);
    wrSeq('{AW, 8'h20});
    host.start();
    put(AW, 1'b1);
    put(CMD_BLK_RD, 1'b1);
    host.start();
    put(AR, 1'b1);
    crc = crcStep(crcStep(crcStep(8'h00, AW), CMD_BLK_RD), AR);
    for (int i = 0; i <= 32; i++) begin
      e = (i == 0) ? BLK_RD_COUNT : 8'h3F + 8'(i);
      host.recvByte(1'b1, d);
      check(d, e);
      crc = crcStep(crc, e);
    end
    host.recvByte(1'b0, d);
    check(d, crc);
    host.stop();
    $display("test block done");
  endtask

  initial begin
    rstn = 1'b0;
    hiPin = 1'b1;
    loPin = 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    testBoot();
    testRam();
    testErase();
    testNoErase();
    testBlock();
    summarize();
  end

  // The ceiling leaves ample room over the expected run of about 66000 cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      bad_count++;
      summarize();
    end
  end
endmodule
